// File: verilog/misc_regs.sv
// Miscellaneous sound chip registers behind an AHB-Lite slave.
// Assumes a single master, word transfers and inputs synchronous to hclk.
//
// What this block does
// R1: Config bit 0 picks 64K or 15K base.
// R2: Pot status: one busy bit per pot.
// R3: Status bit zero means counter value valid.
// R4: Trigger clears counters; stop at threshold/228.
// R5: Restart write reloads every audio timer.
// R6: Restart clears channel flops, inverted to one.
// R7: Restart silences channels 1-2, enables 3-4.
// R8: Key code bit7 control, bit6 shift.
// R9: Key code changes only on key press.
// R10: Low key code bits hold scan code.
// R11: Clear strobe zeroes status bits 5-7, except a bit whose event arrives in the same cycle.
// R12: Random port reads top noise byte.
// R13: Noise advances every system clock cycle.
// R14: Config bit 7 shortens noise to nine bits.
// R15: Noise register never reaches all zero.
// R16: Reset state reads 00 on random port.
//
// The AHB-Lite slave port was decided locally.
`default_nettype none
module misc_regs (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [7:0] pot_reached,
    input wire logic key_press,
    input wire misc_regs_pkg::key_event_t key_event,
    input wire logic [2:0] sk_event,
    input wire logic [4:0] sk_live,
    input wire logic [3:0] chan_toggle,
    output logic [7:0] audio_config,
    output logic slow_clk_15k,
    output logic timer_reload,
    output logic [3:0] chan_enable,
    output misc_regs_pkg::pot_count_t pot_count,
    output logic [7:0] pot_status
);
    import misc_regs_pkg::*;

    ahb_req_t aph_d;
    ahb_req_t dph_q;
    logic [7:0] key_code_q;
    logic [7:0] sk_status_q;
    logic [3:0] chan_ff_q;
    logic [6:0] tick_cnt_q;
    logic tick_q;
    logic [NOISE_W-1:0] noise_q;
    logic wr_cfg;
    logic wr_restart;
    logic wr_sk_clear;
    logic wr_pot_go;
    logic [7:0] rd_byte;

    function automatic logic at(input logic [29:0] word, input logic [15:0] idx);
        at = (word == {14'h0000, idx});
    endfunction

    // ==========================================================
    // Bus slave
    // Zero wait states: read data is latched at the address phase edge,
    // so the noise byte is the value at the moment of the request.
    always_comb begin
        aph_d.valid = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
        aph_d.wr = hwrite;
        aph_d.word = haddr[31:2];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_q <= '0;
        end else if (hready) begin
            dph_q <= aph_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp <= HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        if (at(aph_d.word, IDX_POT_STATUS)) begin
            rd_byte = pot_status; // R2
        end else if (at(aph_d.word, IDX_KEY_CODE)) begin
            rd_byte = key_code_q;
        end else if (at(aph_d.word, IDX_NOISE)) begin
            rd_byte = noise_q[NOISE_W-1:NOISE_W-8]; // R12
        end else if (at(aph_d.word, IDX_SK_STATUS)) begin
            rd_byte = sk_status_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= RDATA_ZERO;
        end else if (aph_d.valid && !aph_d.wr) begin
            hrdata <= {24'h000000, rd_byte};
        end
    end

    assign wr_cfg = dph_q.valid && dph_q.wr && at(dph_q.word, IDX_AUDIO_CFG);
    assign wr_restart = dph_q.valid && dph_q.wr && at(dph_q.word, IDX_TIMER_RESTART);
    assign wr_sk_clear = dph_q.valid && dph_q.wr && at(dph_q.word, IDX_SK_CLEAR);
    assign wr_pot_go = dph_q.valid && dph_q.wr && at(dph_q.word, IDX_POT_TRIGGER);

    // ==========================================================
    // Audio configuration
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            audio_config <= AUDIO_CFG_RESET;
            slow_clk_15k <= 1'b0;
        end else if (wr_cfg) begin
            audio_config <= hwdata[7:0];
            slow_clk_15k <= hwdata[CFG_SLOW_15K_BIT]; // R1
        end
    end

    // ==========================================================
    // Timer restart and channel output flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_reload <= 1'b0;
        end else begin
            timer_reload <= wr_restart; // R5
        end
    end

    // Restart wins over a timer toggle in the same cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chan_ff_q <= 4'h0;
        end else if (wr_restart) begin
            chan_ff_q <= 4'h0; // R6
        end else begin
            chan_ff_q <= chan_ff_q ^ chan_toggle;
        end
    end

    // Channels 1-2 follow the flop, channels 3-4 its inverse, so with the
    // filters off a restart leaves 1-2 quiet and 3-4 sounding.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chan_enable <= 4'h0;
        end else if (wr_restart) begin
            chan_enable <= 4'hC; // R7
        end else begin
            chan_enable[0] <= chan_ff_q[0] ^ chan_toggle[0];
            chan_enable[1] <= chan_ff_q[1] ^ chan_toggle[1];
            chan_enable[2] <= ~(chan_ff_q[2] ^ chan_toggle[2]); // R6
            chan_enable[3] <= ~(chan_ff_q[3] ^ chan_toggle[3]); // R6
        end
    end

    // ==========================================================
    // System tick and noise generator
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt_q <= TICK_ZERO;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (tick_cnt_q == TICK_LAST);
            tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? TICK_ZERO : tick_cnt_q + 7'h01;
        end
    end

    noise_lfsr u_noise (
        .hclk(hclk),
        .hresetn(hresetn),
        .step(tick_q), // R13
        .short_mode(audio_config[CFG_POLY9_BIT]), // R14
        .state_q(noise_q)
    );

    // ==========================================================
    // Pot counters
    // Counting runs at the system tick; the limit guards a pot that never
    // crosses its threshold.
    for (genvar i = 0; i < 8; i++) begin : g_pot
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                pot_count[i] <= POT_ZERO;
                pot_status[i] <= 1'b0;
            end else if (wr_pot_go) begin
                pot_count[i] <= POT_ZERO; // R4
                pot_status[i] <= 1'b1; // R4
            end else if (pot_status[i]) begin
                if (pot_reached[i] || pot_count[i] == POT_LIMIT) begin
                    pot_status[i] <= 1'b0; // R3
                end else if (tick_q) begin
                    pot_count[i] <= pot_count[i] + 8'h01; // R4
                end
            end
        end
    end

    // ==========================================================
    // Keyboard code
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            key_code_q <= KEY_CODE_RESET;
        end else if (key_press) begin
            key_code_q[KEY_CTRL_BIT] <= key_event.ctrl; // R8
            key_code_q[KEY_SHIFT_BIT] <= key_event.shift; // R8
            key_code_q[5:0] <= key_event.scan; // R10
        end
    end

    // ==========================================================
    // Serial and keyboard status
    // An event in the clearing cycle survives the clear.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sk_status_q <= 8'h00;
        end else begin
            sk_status_q[4:0] <= sk_live;
            for (int b = 0; b < 3; b++) begin
                if (sk_event[b]) begin
                    sk_status_q[SK_CLR_LO+b] <= 1'b1;
                end else if (wr_sk_clear) begin
                    sk_status_q[SK_CLR_LO+b] <= 1'b0; // R11
                end
            end
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence restart_wr_s;
        wr_restart;
    endsequence

    sequence reload_pulse_s;
        timer_reload ##1 !timer_reload;
    endsequence

    sequence pot_go_s;
        wr_pot_go;
    endsequence

    slow_clock_sel_a: assert property (wr_cfg |=> slow_clk_15k == $past(hwdata[0])) // R1
        else $error("slow clock select does not follow config bit 0");
    pot_busy_a: assert property (pot_go_s |=> pot_status == POT_ALL_BUSY) // R2
        else $error("pot status not all busy after trigger");
    pot_valid_a: assert property (!pot_status[0] && !wr_pot_go |=> $stable(pot_count[0])) // R3
        else $error("pot count moved after completion");
    pot_limit_a: assert property (pot_status[1] && pot_count[1] == POT_LIMIT && !wr_pot_go
        |=> !pot_status[1] && pot_count[1] == POT_LIMIT) // R4
        else $error("pot counter ran past its limit");
    pot_clear_a: assert property (pot_go_s |=> pot_count[2] == POT_ZERO) // R4
        else $error("pot counter not cleared by trigger");
    timer_reload_a: assert property (restart_wr_s |=> reload_pulse_s) // R5
        else $error("timer reload is not a single pulse");
    chan_restart_a: assert property (restart_wr_s |=> chan_ff_q == 4'h0) // R6
        else $error("channel flops not cleared by restart");
    chan_enable_a: assert property (restart_wr_s |=> chan_enable == 4'hC) // R7
        else $error("restart did not quiet channels 1-2 and enable 3-4");
    key_mods_a: assert property (key_press |=> key_code_q[7:6] ==
        {$past(key_event.ctrl), $past(key_event.shift)}) // R8
        else $error("modifier bits wrong after key press");
    key_hold_a: assert property (!key_press |=> $stable(key_code_q)) // R9
        else $error("key code changed without a key press");
    sk_clear_a: assert property (wr_sk_clear && sk_event == 3'h0 |=> sk_status_q[7:5] == 3'h0) // R11
        else $error("status bits 5-7 not cleared");
    noise_read_a: assert property (aph_d.valid && !aph_d.wr && at(aph_d.word, IDX_NOISE)
        |=> hrdata[7:0] == $past(noise_q[16:9])) // R12
        else $error("random port does not show top noise byte");
    noise_step_a: assert property (!tick_q |=> $stable(noise_q)) // R13
        else $error("noise advanced without a system tick");
    noise_short_a: assert property (audio_config[CFG_POLY9_BIT] |=> $stable(noise_q[7:0])) // R14
        else $error("short mode disturbed low noise bits");
    noise_nonzero_a: assert property (noise_q != NOISE_ZERO) // R15
        else $error("noise register reached all zero");
    noise_seed_a: assert property ($rose(hreadyout) |-> noise_q[16:9] == 8'h00) // R16
        else $error("noise does not start at the 00 state");

endmodule
`default_nettype wire

// File: verilog/misc_regs_pkg.sv
// Package for the sound chip miscellaneous register bank.
// Assumes a 200 MHz AHB-Lite clock and a 32-bit data bus.
`default_nettype none
package misc_regs_pkg;

    // ==========================================================
    // Register indices; byte address is four times the index.
    localparam logic [15:0] IDX_POT_STATUS = 16'hD208;
    localparam logic [15:0] IDX_AUDIO_CFG = 16'hD208;
    localparam logic [15:0] IDX_TIMER_RESTART = 16'hD209;
    localparam logic [15:0] IDX_KEY_CODE = 16'hD209;
    localparam logic [15:0] IDX_SK_CLEAR = 16'hD20A;
    localparam logic [15:0] IDX_NOISE = 16'hD20A;
    localparam logic [15:0] IDX_POT_TRIGGER = 16'hD20B;
    localparam logic [15:0] IDX_SK_STATUS = 16'hD20F;

    // ==========================================================
    // Field positions and reset values.
    localparam int CFG_SLOW_15K_BIT = 0;
    localparam int CFG_HP1_BIT = 2;
    localparam int CFG_HP2_BIT = 1;
    localparam int CFG_POLY9_BIT = 7;
    localparam int KEY_CTRL_BIT = 7;
    localparam int KEY_SHIFT_BIT = 6;
    localparam int SK_CLR_LO = 5;
    localparam logic [7:0] AUDIO_CFG_RESET = 8'h00;
    localparam logic [7:0] KEY_CODE_RESET = 8'h00;
    localparam logic [7:0] POT_LIMIT = 8'hE4;
    localparam logic [7:0] POT_ZERO = 8'h00;
    localparam logic [7:0] POT_ALL_BUSY = 8'hFF;
    localparam logic [7:0] POT_ALL_DONE = 8'h00;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    // ==========================================================
    // Noise generator: seed reads as 00 on the random port.
    localparam int NOISE_W = 17;
    localparam int NOISE_SHORT_LO = 8;
    localparam logic [16:0] NOISE_SEED = 17'h00100;
    localparam logic [16:0] NOISE_ZERO = 17'h00000;
    localparam int TAP_LONG = 3;
    localparam int TAP_SHORT = 12;

    // ==========================================================
    // Timing: one system tick per 1.79 MHz cycle, rounded down.
    localparam longint HCLK_HZ = 200_000_000;
    localparam longint SYS_CLK_HZ = 1_790_000;
    localparam int TICK_DIV = int'(HCLK_HZ / SYS_CLK_HZ);
    localparam logic [6:0] TICK_LAST = 7'(TICK_DIV - 1);
    localparam logic [6:0] TICK_ZERO = 7'h00;

    // ==========================================================
    // AHB-Lite codes and carriers.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic HRESP_OKAY = 1'b0;

    typedef struct packed {
        logic valid;
        logic wr;
        logic [29:0] word;
    } ahb_req_t;

    typedef struct packed {
        logic ctrl;
        logic shift;
        logic [5:0] scan;
    } key_event_t;

    typedef logic [7:0][7:0] pot_count_t;

endpackage
`default_nettype wire

// File: verilog/noise_lfsr.sv
// XOR feedback noise generator, 17 bits or shortened to 9 bits.
// Assumes one step pulse per system tick from the register bank.
`default_nettype none
module noise_lfsr (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic step,
    input wire logic short_mode,
    output logic [misc_regs_pkg::NOISE_W-1:0] state_q
);
    import misc_regs_pkg::*;

    logic [NOISE_W-1:0] state_d;
    logic fb;

    // ==========================================================
    // Next state
    // The short mode only shifts the top nine bits, so the port that
    // reads the top byte sees the shorter sequence directly.
    always_comb begin
        state_d = state_q;
        if (short_mode) begin
            fb = state_q[NOISE_SHORT_LO] ^ state_q[TAP_SHORT];
            state_d[NOISE_W-1:NOISE_SHORT_LO] = {fb, state_q[NOISE_W-1:NOISE_SHORT_LO+1]};
            if (state_q[NOISE_W-1:NOISE_SHORT_LO] == '0) begin
                state_d[NOISE_SHORT_LO] = 1'b1; // R15
            end
        end else begin
            fb = state_q[0] ^ state_q[TAP_LONG];
            state_d = {fb, state_q[NOISE_W-1:1]};
            if (state_q == NOISE_ZERO) begin
                state_d = NOISE_SEED; // R15
            end
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= NOISE_SEED; // R16
        end else if (step) begin
            state_q <= state_d; // R13
        end
    end

endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the miscellaneous sound chip register bank.
// Assumes the bench is the only AHB-Lite master and drives every side input itself.
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_fail++; \
    $display("FAIL t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import misc_regs_pkg::*;

    // ==========================================================
    // Clock, reset and design inputs.
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [7:0] pot_reached = 8'h00;
    logic key_press = 1'b0;
    key_event_t key_event = 8'h00;
    logic [2:0] sk_event = 3'h0;
    logic [4:0] sk_live = 5'h00;
    logic [3:0] chan_toggle = 4'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [7:0] audio_config;
    logic slow_clk_15k;
    logic timer_reload;
    logic [3:0] chan_enable;
    pot_count_t pot_count;
    logic [7:0] pot_status;
    logic [31:0] rd;
    logic [7:0] v;
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;
    int rel = 0;

    initial begin
        forever #2.5 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        cyc <= cyc + 1;
    end

    misc_regs dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pot_reached(pot_reached), .key_press(key_press), .key_event(key_event),
        .sk_event(sk_event), .sk_live(sk_live), .chan_toggle(chan_toggle),
        .audio_config(audio_config), .slow_clk_15k(slow_clk_15k),
        .timer_reload(timer_reload), .chan_enable(chan_enable),
        .pot_count(pot_count), .pot_status(pot_status)
    );

    // ==========================================================
    // Bus access and helpers.
    task automatic bus(input logic [15:0] idx, input logic wr, input logic [7:0] wd,
                       output logic [31:0] data);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {14'h0000, idx, 2'b00};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h00_0000, wd};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        data = hrdata;
        `CHK(hresp, HRESP_OKAY)
    endtask

    task automatic pulse_cycles(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask

    // Model of the long generator only; the short mode is checked through the config copy.
    function automatic logic [7:0] noise_top(input int n);
        logic [16:0] s;
        s = NOISE_SEED;
        for (int i = 0; i < n; i++) begin
            s = {s[0] ^ s[TAP_LONG], s[16:1]};
        end
        return s[16:9];
    endfunction

    // The tick phase is only known to within one step, so neighbouring states are accepted.
    task automatic check_noise();
        int n;
        logic [7:0] e;
        n = (cyc - rel) / TICK_DIV;
        bus(IDX_NOISE, 1'b0, 8'h00, rd);
        e = noise_top(n);
        if (noise_top(n + 1) === rd[7:0] || (n > 0 && noise_top(n - 1) === rd[7:0])) begin
            e = rd[7:0];
        end
        `CHK(rd, {24'h00_0000, e})
    endtask

    task automatic close_out();
        if (n_fail == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #200000;
        n_fail++;
        close_out();
    end

    // ==========================================================
    // Test sequence.
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        rel = cyc;
        repeat (2) @(posedge hclk);
        bus(IDX_NOISE, 1'b0, 8'h00, rd);
        `CHK(rd, RDATA_ZERO)
        bus(IDX_AUDIO_CFG, 1'b1, 8'h01, rd);
        #1;
        `CHK(slow_clk_15k, 1'b1)
        bus(IDX_AUDIO_CFG, 1'b1, 8'h00, rd);
        #1;
        `CHK(slow_clk_15k, 1'b0)
        chan_toggle <= 4'hF;
        @(posedge hclk);
        chan_toggle <= 4'h0;
        pulse_cycles(3);
        `CHK(chan_enable, 4'h3)
        bus(IDX_TIMER_RESTART, 1'b1, 8'h5A, rd);
        #1;
        `CHK(timer_reload, 1'b1)
        `CHK(chan_enable, 4'hC)
        pulse_cycles(1);
        `CHK(timer_reload, 1'b0)
        key_event <= {1'b1, 1'b0, 6'h15};
        key_press <= 1'b1;
        @(posedge hclk);
        key_press <= 1'b0;
        key_event <= {1'b0, 1'b1, 6'h2A};
        bus(IDX_KEY_CODE, 1'b0, 8'h00, rd);
        `CHK(rd, 32'h0000_0095)
        key_press <= 1'b1;
        @(posedge hclk);
        key_press <= 1'b0;
        key_event <= {1'b1, 1'b1, 6'h3F};
        bus(IDX_KEY_CODE, 1'b0, 8'h00, rd);
        `CHK(rd, 32'h0000_006A)
        pulse_cycles(4);
        bus(IDX_KEY_CODE, 1'b0, 8'h00, rd);
        `CHK(rd, 32'h0000_006A)
        sk_live <= 5'h0A;
        sk_event <= 3'h7;
        @(posedge hclk);
        sk_event <= 3'h0;
        bus(IDX_SK_STATUS, 1'b0, 8'h00, rd);
        `CHK(rd, 32'h0000_00EA)
        bus(IDX_SK_CLEAR, 1'b1, 8'hFF, rd);
        bus(IDX_SK_STATUS, 1'b0, 8'h00, rd);
        `CHK(rd, 32'h0000_000A)
        bus(16'hD20C, 1'b0, 8'h00, rd);
        `CHK(rd, RDATA_ZERO)
        bus(IDX_POT_TRIGGER, 1'b1, 8'h00, rd);
        #1;
        `CHK(pot_status, POT_ALL_BUSY)
        `CHK(pot_count, 64'h0)
        pulse_cycles(5 * TICK_DIV);
        pot_reached <= 8'h01;
        pulse_cycles(3);
        `CHK(pot_status, 8'hFE)
        v = pot_count[0];
        pulse_cycles(3 * TICK_DIV);
        `CHK(pot_count[0], v)
        for (int i = 0; i < 30000 && pot_status !== POT_ALL_DONE; i++) begin
            pulse_cycles(1);
        end
        `CHK(pot_status, POT_ALL_DONE)
        for (int i = 1; i < 8; i++) begin
            `CHK(pot_count[i], POT_LIMIT)
        end
        pulse_cycles(2 * TICK_DIV);
        `CHK(pot_count[1], POT_LIMIT)
        bus(IDX_POT_STATUS, 1'b0, 8'h00, rd);
        `CHK(rd, RDATA_ZERO)
        check_noise();
        pulse_cycles(3 * TICK_DIV);
        check_noise();
        bus(IDX_AUDIO_CFG, 1'b1, 8'h80, rd);
        #1;
        `CHK(audio_config, 8'h80)
        close_out();
    end
endmodule
`undef CHK
`default_nettype wire
